// file: hw/prot_pkg.sv
// Purpose: Shared constants for the block protection logic
// Assumes: 32-bit register words on an AXI4-Lite slave
// Notes:   Offsets are byte addresses
package prot_pkg;
	localparam int unsigned NUM_BLOCKS  = 8;
	localparam int unsigned ADDR_W      = 8;
	localparam logic [7:0]  OFS_BLKSEL  = 8'h00;
	localparam logic [7:0]  OFS_PW0     = 8'h04;
	localparam logic [7:0]  OFS_PW1     = 8'h08;
	localparam logic [7:0]  OFS_PW2     = 8'h0C;
	localparam logic [7:0]  OFS_CMD     = 8'h10;
	localparam logic [7:0]  OFS_STATUS  = 8'h14;
	localparam logic [7:0]  OFS_INTSTAT = 8'h18;
	localparam logic [7:0]  OFS_INTMASK = 8'h1C;
	localparam int unsigned CMD_CNT_LSB = 0;
	localparam int unsigned CMD_OP_LSB  = 4;
	localparam int unsigned CMD_PRT_LSB = 8;
	localparam int unsigned ST_UNLOCK   = 0;
	localparam int unsigned ST_HASPW    = 1;
	localparam int unsigned ST_REC_LSB  = 2;
	localparam int unsigned ST_PERM     = 4;
	localparam int unsigned ST_LOWV     = 5;
	localparam int unsigned ST_RDBUSY   = 6;
	localparam int unsigned ST_BUSY     = 7;
	localparam int unsigned ST_COPY     = 8;
	localparam int unsigned ST_ERASE    = 9;
	localparam int unsigned ST_PRT_LSB  = 16;
	localparam int unsigned SUP_BIT     = 2;
	localparam logic [1:0]  MODE_RW     = 2'h0;
	localparam logic [1:0]  MODE_NA     = 2'h1;
	localparam logic [1:0]  MODE_RO     = 2'h2;
	localparam logic [31:0] NO_PASSWORD = 32'hFFFFFFFF;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	localparam logic [2:0]  PROT_RST    = 3'h0;
	localparam logic [1:0]  REC_RST     = 2'h0;
	typedef enum logic [2:0] {OP_NONE, OP_SETPW, OP_UNLOCK, OP_LOCK, OP_PROT} op_e;
endpackage

// file: hw/prot_if.sv
// Purpose: Links core, password bank and access checker
// Assumes: One clock domain
// Notes:   Word array holds the staged password
`timescale 1ns/1ps
`default_nettype none
interface prot_if #(parameter int unsigned NB = 8);
	localparam int unsigned BW = $clog2(NB);
	logic          pwWr;
	logic [BW-1:0] pwBlk;
	logic [1:0]    pwCnt;
	logic [31:0]   pwWord [3];
	logic [NB-1:0] hasPw;
	logic          pwMatch;
	logic [BW-1:0] accBlk;
	logic          accWr;
	logic          accPriv;
	logic          blk0Unl;
	logic          blkUnl;
	logic [2:0]    prot0;
	logic [2:0]    protB;
	logic          allowed;
	modport core (output pwWr, pwBlk, pwCnt, pwWord, accBlk, accWr, accPriv, blk0Unl,
		blkUnl, prot0, protB, input hasPw, pwMatch, allowed);
	modport bank (input pwWr, pwBlk, pwCnt, pwWord, output hasPw, pwMatch);
	modport chk (input accBlk, accWr, accPriv, blk0Unl, blkUnl, prot0, protB, hasPw,
		output allowed);
endinterface
`default_nettype wire

// file: hw/pw_bank.sv
// Purpose: Per-block password store and comparator
// Assumes: por_n clears stored passwords
// Notes:   Password words carry no reset
`timescale 1ns/1ps
`default_nettype none
module pw_bank #(
	parameter int unsigned NB = 8
) (
	input wire logic ref_clk,
	input wire logic por_n,
	prot_if.bank     pif
);
	logic [31:0] word_r [NB][3];
	logic [1:0]  cnt_r  [NB];
	logic [2:0]  eq;

	genvar g;
	for (g = 0; g < NB; g++) begin : gHas
		assign pif.hasPw[g] = (cnt_r[g] != 2'h0);
	end
	for (g = 0; g < 3; g++) begin : gEq
		assign eq[g] = (2'(g) >= pif.pwCnt) || (word_r[pif.pwBlk][g] == pif.pwWord[g]);
	end
	// Same length and every word equal
	assign pif.pwMatch = pif.hasPw[pif.pwBlk] && (cnt_r[pif.pwBlk] == pif.pwCnt) && (&eq);

	always_ff @(posedge ref_clk or negedge por_n) begin
		if (!por_n) begin
			cnt_r <= '{default: 2'h0};
		end else if (pif.pwWr) begin
			cnt_r[pif.pwBlk] <= pif.pwCnt;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (pif.pwWr) begin
			word_r[pif.pwBlk] <= pif.pwWord;
		end
	end
endmodule
`default_nettype wire

// file: hw/access_check.sv
// Purpose: Read and write permission for one block access
// Assumes: Inputs steady within the cycle
// Notes:   Mode code 3 treated as no access
`timescale 1ns/1ps
`default_nettype none
module access_check (
	prot_if.chk pif
);
	logic [2:0] eff;
	logic       locked;
	logic       gate;
	logic       rdOk;
	logic       wrOk;

	assign eff    = (pif.accBlk == '0) ? pif.prot0 : (pif.prot0 | pif.protB);
	assign locked = pif.hasPw[pif.accBlk] && !pif.blkUnl;
	assign gate   = (pif.accBlk == '0) || pif.blk0Unl;

	always_comb begin
		unique case (eff[1:0])
			prot_pkg::MODE_RW: begin
				rdOk = 1'b1;
				wrOk = !locked;
			end
			prot_pkg::MODE_RO: begin
				rdOk = !locked;
				wrOk = 1'b0;
			end
			default: begin
				rdOk = pif.hasPw[pif.accBlk] && pif.blkUnl;
				wrOk = rdOk;
			end
		endcase
	end

	// Supervisor-only blocks refuse user mode
	assign pif.allowed = gate && (!eff[prot_pkg::SUP_BIT] || pif.accPriv)
		&& (pif.accWr ? wrOk : rdOk);
endmodule
`default_nettype wire

// file: hw/eeprom_block_protection.sv
// Purpose: Block password, lock and access protection with interrupt
// Assumes: AXI4-Lite master, one write and one read in flight
// Notes:   Passwords and protection survive rst_n, cleared by por_n
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Password is one to three words
// - Password accepted once, later attempts error
// - New password leaves block unlocked
// - Locked block 0 denies all others
// - Other blocks' protection readable only with block 0 open
// - Effective protection ORs block 0 flags
// - Supervisor flag refuses user mode
// - Read-write mode: locked means read only
// - No-access mode: only unlocked password allows
// - Read-only mode: locked means no access
// - Unlock needs exact word and count match
// - Lock state reads 1 unlocked, 0 locked
// - Recovery outcome readable after reset
// - Completion raises interrupt when enabled
// - Single completion interrupt, cleared by software
// - Either unit's enable gates the interrupt
// - Forbidden write flags permission error
module eeprom_block_protection #(
	parameter int unsigned NB = prot_pkg::NUM_BLOCKS
) (
	input  wire logic                        ref_clk,
	input  wire logic                        rst_n,
	input  wire logic                        por_n,
	input  wire logic [prot_pkg::ADDR_W-1:0] awaddr,
	input  wire logic                        awvalid,
	output logic                             awready,
	input  wire logic [31:0]                 wdata,
	input  wire logic [3:0]                  wstrb,
	input  wire logic                        wvalid,
	output logic                             wready,
	output logic [1:0]                       bresp,
	output logic                             bvalid,
	input  wire logic                        bready,
	input  wire logic [prot_pkg::ADDR_W-1:0] araddr,
	input  wire logic                        arvalid,
	output logic                             arready,
	output logic [31:0]                      rdata,
	output logic [1:0]                       rresp,
	output logic                             rvalid,
	input  wire logic                        rready,
	input  wire logic                        accReq,
	input  wire logic [$clog2(NB)-1:0]       accBlk,
	input  wire logic                        accWr,
	input  wire logic                        accPriv,
	output logic                             accGrant,
	output logic                             accDenied,
	input  wire logic                        progDone,
	input  wire logic                        engBusy,
	input  wire logic                        engCopy,
	input  wire logic                        engErase,
	input  wire logic                        engLowVolt,
	input  wire logic [1:0]                  recCode,
	input  wire logic                        flashIntEn,
	output logic                             irq
);
	localparam int unsigned BW = $clog2(NB);

	// ----------
	// Storage
	// ----------
	logic                        awGot_r, wGot_r, awready_r, wready_r;
	logic [prot_pkg::ADDR_W-1:0] awAddr_r;
	logic [31:0]                 wData_r;
	logic [3:0]                  wStrb_r;
	logic                        bvalid_r, arready_r, rvalid_r;
	logic [1:0]                  bresp_r, rresp_r;
	logic [31:0]                 rdata_r;
	logic [BW-1:0]               blkSel_r;
	logic [31:0]                 pw_r [3];
	logic [NB-1:0]               unl_r, unlNxt, protSet_r;
	logic [2:0]                  prot_r [NB];
	logic                        permErr_r, lowV_r, rdBusy_r;
	logic [1:0]                  rec_r;
	logic                        intStat_r, intMask_r, irq_r, accGrant_r, accDenied_r;

	// ----------
	// Decode wires
	// ----------
	logic                        awHs, wHs, arHs, doWr, awGotNxt, wGotNxt;
	logic                        wBlk, wCmd, wStat, wMask, wMapped, rMapped, rdInt;
	logic [31:0]                 rdMux, stWord, strbMask;
	prot_pkg::op_e               cmdOp;
	logic [1:0]                  cmdCnt;
	logic [2:0]                  cmdPrt, isFf;
	logic                        cmdGate, setPwOk, setPwErr, unlockOk, lockCmd;
	logic                        protOk, protErr, permSet, protVis;
	logic [NB-1:0]               lockState;

	// ----------
	// Submodules
	// ----------
	prot_if #(.NB(NB)) pif ();

	pw_bank #(.NB(NB)) uBank (
		.ref_clk (ref_clk),
		.por_n   (por_n),
		.pif     (pif.bank)
	);

	access_check uChk (
		.pif (pif.chk)
	);

	assign pif.pwWr    = setPwOk;
	assign pif.pwBlk   = blkSel_r;
	assign pif.pwCnt   = cmdCnt;
	assign pif.pwWord  = pw_r;
	assign pif.accBlk  = accBlk;
	assign pif.accWr   = accWr;
	assign pif.accPriv = accPriv;
	assign pif.blk0Unl = lockState[0];
	assign pif.blkUnl  = unl_r[accBlk];
	assign pif.prot0   = prot_r[0];
	assign pif.protB   = prot_r[accBlk];

	// ----------
	// AXI4-Lite handshakes
	// ----------
	assign awHs     = awvalid && awready_r;
	assign wHs      = wvalid && wready_r;
	assign arHs     = arvalid && arready_r;
	assign doWr     = awGot_r && wGot_r && !bvalid_r;
	assign awGotNxt = !doWr && (awGot_r || awHs);
	assign wGotNxt  = !doWr && (wGot_r || wHs);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			awGot_r   <= 1'b0;
			wGot_r    <= 1'b0;
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			awAddr_r  <= '0;
			wData_r   <= 32'h00000000;
			wStrb_r   <= 4'h0;
		end else begin
			awGot_r   <= awGotNxt;
			wGot_r    <= wGotNxt;
			awready_r <= !awGotNxt;
			wready_r  <= !wGotNxt;
			if (awHs) begin
				awAddr_r <= awaddr;
			end
			if (wHs) begin
				wData_r <= wdata;
				wStrb_r <= wstrb;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bvalid_r <= 1'b0;
			bresp_r  <= prot_pkg::RESP_OKAY;
		end else if (doWr) begin
			bvalid_r <= 1'b1;
			bresp_r  <= wMapped ? prot_pkg::RESP_OKAY : prot_pkg::RESP_SLVERR;
		end else if (bready) begin
			bvalid_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h00000000;
			rresp_r   <= prot_pkg::RESP_OKAY;
		end else begin
			arready_r <= !(arHs || (rvalid_r && !rready));
			if (arHs) begin
				rvalid_r <= 1'b1;
				rdata_r  <= rdMux;
				rresp_r  <= rMapped ? prot_pkg::RESP_OKAY : prot_pkg::RESP_SLVERR;
			end else if (rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	// ----------
	// Register decode
	// ----------
	assign wBlk    = doWr && (awAddr_r == prot_pkg::OFS_BLKSEL);
	assign wCmd    = doWr && (awAddr_r == prot_pkg::OFS_CMD);
	assign wStat   = doWr && (awAddr_r == prot_pkg::OFS_STATUS);
	assign wMask   = doWr && (awAddr_r == prot_pkg::OFS_INTMASK);
	assign wMapped = (awAddr_r[7:4] == 4'h0) || (awAddr_r[7:4] == 4'h1 && awAddr_r[1:0] == 2'h0);
	assign rMapped = (araddr[7:4] == 4'h0) || (araddr[7:4] == 4'h1 && araddr[1:0] == 2'h0);
	assign rdInt   = arHs && (araddr == prot_pkg::OFS_INTSTAT);
	assign strbMask = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}}, {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};

	assign lockState = unl_r | ~pif.hasPw;
	assign protVis   = (blkSel_r == '0) || lockState[0];

	always_comb begin
		stWord = 32'h00000000;
		stWord[prot_pkg::ST_UNLOCK] = lockState[blkSel_r];
		stWord[prot_pkg::ST_HASPW] = pif.hasPw[blkSel_r];
		stWord[prot_pkg::ST_REC_LSB +: 2] = rec_r;
		stWord[prot_pkg::ST_PERM] = permErr_r;
		stWord[prot_pkg::ST_LOWV] = lowV_r;
		stWord[prot_pkg::ST_RDBUSY] = rdBusy_r;
		stWord[prot_pkg::ST_BUSY] = engBusy;
		stWord[prot_pkg::ST_COPY] = engCopy;
		stWord[prot_pkg::ST_ERASE] = engErase;
		stWord[prot_pkg::ST_PRT_LSB +: 3] = protVis ? prot_r[blkSel_r] : 3'h0;
	end

	assign rdMux = (araddr == prot_pkg::OFS_BLKSEL)  ? 32'(blkSel_r) :
	               (araddr == prot_pkg::OFS_STATUS)  ? stWord :
	               (araddr == prot_pkg::OFS_INTSTAT) ? {31'h0, intStat_r} :
	               (araddr == prot_pkg::OFS_INTMASK) ? {31'h0, intMask_r} : 32'h00000000;

	// ----------
	// Commands
	// ----------
	assign cmdOp  = prot_pkg::op_e'(wData_r[prot_pkg::CMD_OP_LSB +: 3]);
	assign cmdCnt = wData_r[prot_pkg::CMD_CNT_LSB +: 2];
	assign cmdPrt = wData_r[prot_pkg::CMD_PRT_LSB +: 3];

	genvar g;
	for (g = 0; g < 3; g++) begin : gFf
		assign isFf[g] = (2'(g) < cmdCnt) && (pw_r[g] == prot_pkg::NO_PASSWORD);
	end

	assign cmdGate  = (blkSel_r == '0) || lockState[0];
	assign setPwOk  = wCmd && (cmdOp == prot_pkg::OP_SETPW) && (cmdCnt != 2'h0)
		&& !(|isFf) && !pif.hasPw[blkSel_r] && cmdGate;
	assign setPwErr = wCmd && (cmdOp == prot_pkg::OP_SETPW) && !setPwOk;
	assign unlockOk = wCmd && (cmdOp == prot_pkg::OP_UNLOCK) && pif.pwMatch;
	assign lockCmd  = wCmd && (cmdOp == prot_pkg::OP_LOCK);
	assign protOk   = wCmd && (cmdOp == prot_pkg::OP_PROT) && !protSet_r[blkSel_r] && cmdGate;
	assign protErr  = wCmd && (cmdOp == prot_pkg::OP_PROT) && !protOk;
	assign permSet  = setPwErr || protErr || (accReq && accWr && !pif.allowed);

	always_comb begin
		unlNxt = unl_r;
		if (setPwOk || unlockOk) begin
			unlNxt[blkSel_r] = 1'b1;
		end
		if (lockCmd) begin
			if (blkSel_r == '0) begin
				unlNxt = '0;
			end else begin
				unlNxt[blkSel_r] = 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			blkSel_r <= '0;
			pw_r     <= '{default: 32'h00000000};
			unl_r    <= '0;
		end else begin
			unl_r <= unlNxt;
			if (wBlk) begin
				blkSel_r <= wData_r[BW-1:0];
			end
			for (int i = 0; i < 3; i++) begin
				if (doWr && awAddr_r == prot_pkg::OFS_PW0 + 8'(4 * i)) begin
					pw_r[i] <= (pw_r[i] & ~strbMask) | (wData_r & strbMask);
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge por_n) begin
		if (!por_n) begin
			prot_r    <= '{default: prot_pkg::PROT_RST};
			protSet_r <= '0;
		end else if (protOk) begin
			prot_r[blkSel_r]    <= cmdPrt;
			protSet_r[blkSel_r] <= 1'b1;
		end
	end

	// ----------
	// Status and access
	// ----------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			permErr_r   <= 1'b0;
			lowV_r      <= 1'b0;
			rdBusy_r    <= 1'b0;
			rec_r       <= prot_pkg::REC_RST;
			accGrant_r  <= 1'b0;
			accDenied_r <= 1'b0;
		end else begin
			permErr_r   <= permSet || (permErr_r && !(wStat && wData_r[prot_pkg::ST_PERM]));
			lowV_r      <= engLowVolt || (lowV_r && !(wStat && wData_r[prot_pkg::ST_LOWV]));
			rdBusy_r    <= (accReq && !accWr && engBusy)
				|| (rdBusy_r && !(wStat && wData_r[prot_pkg::ST_RDBUSY]));
			rec_r       <= recCode;
			accGrant_r  <= accReq && pif.allowed;
			accDenied_r <= accReq && !pif.allowed;
		end
	end

	// ----------
	// Interrupt
	// ----------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			intStat_r <= 1'b0;
			intMask_r <= 1'b0;
			irq_r     <= 1'b0;
		end else begin
			intStat_r <= progDone || (intStat_r && !rdInt);
			irq_r     <= intStat_r && (intMask_r || flashIntEn);
			if (wMask && wStrb_r[0]) begin
				intMask_r <= wData_r[0];
			end
		end
	end

	assign awready   = awready_r;
	assign wready    = wready_r;
	assign bvalid    = bvalid_r;
	assign bresp     = bresp_r;
	assign arready   = arready_r;
	assign rvalid    = rvalid_r;
	assign rdata     = rdata_r;
	assign rresp     = rresp_r;
	assign accGrant  = accGrant_r;
	assign accDenied = accDenied_r;
	assign irq       = irq_r;

	// ----------
	// Checks
	// ----------
	AST_PW_LEN: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wCmd && cmdOp == prot_pkg::OP_SETPW && cmdCnt == 2'h0 |=> $stable(pif.hasPw))
		else $error("zero-length password stored");
	AST_PW_ONCE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wCmd && cmdOp == prot_pkg::OP_SETPW && pif.hasPw[blkSel_r] |=> permErr_r)
		else $error("second password not refused");
	AST_PW_OPEN: assert property (@(posedge ref_clk) disable iff (!rst_n)
		setPwOk |=> unl_r[blkSel_r] && pif.hasPw[blkSel_r])
		else $error("block not unlocked after password set");
	AST_BLK0_GATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		accReq && accBlk != '0 && !lockState[0] |=> accDenied_r && !accGrant_r)
		else $error("access passed locked block 0");
	AST_SUPER: assert property (@(posedge ref_clk) disable iff (!rst_n)
		accReq && !accPriv && prot_r[0][prot_pkg::SUP_BIT] |=> accDenied_r)
		else $error("user access to supervisor block");
	AST_RO_WR: assert property (@(posedge ref_clk) disable iff (!rst_n)
		accReq && accWr && (prot_r[0][1:0] | prot_r[accBlk][1:0]) == prot_pkg::MODE_RO
		|=> !accGrant_r)
		else $error("write granted in read-only mode");
	AST_BAD_PW: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wCmd && cmdOp == prot_pkg::OP_UNLOCK && !pif.pwMatch |=> unl_r == $past(unl_r))
		else $error("mismatched password unlocked");
	AST_PROT_ONCE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		protErr |=> permErr_r && $stable(protSet_r))
		else $error("protection rewrite not refused");
	AST_IRQ: assert property (@(posedge ref_clk) disable iff (!rst_n)
		progDone && intMask_r ##1 intMask_r |=> irq_r)
		else $error("completion did not raise interrupt");
endmodule
`default_nettype wire

// file: bench/axil_host.sv
// Purpose: AXI4-Lite master standing in for core software
// Assumes: One write or one read at a time
// Notes:   Tasks are called from tb_top
`timescale 1ns/1ps
`default_nettype none
module axil_host (
	input  wire logic       ref_clk,
	input  wire logic       awready,
	input  wire logic       wready,
	input  wire logic       bvalid,
	input  wire logic       arready,
	input  wire logic       rvalid,
	output var logic [7:0]  awaddr,
	output var logic        awvalid,
	output var logic [31:0] wdata,
	output var logic [3:0]  wstrb,
	output var logic        wvalid,
	output var logic        bready,
	output var logic [7:0]  araddr,
	output var logic        arvalid,
	output var logic        rready
);
	initial begin
		{awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
		wstrb = 4'hF;
	end
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		fork
			begin
				do @(posedge ref_clk); while (!awready);
				awvalid <= 1'b0;
			end
			begin
				do @(posedge ref_clk); while (!wready);
				wvalid <= 1'b0;
			end
		join
		while (!bvalid) @(posedge ref_clk);
		bready <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge ref_clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge ref_clk); while (!rvalid);
		rready <= 1'b0;
	endtask
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Purpose: Self-checking bench for block protection
// Assumes: Expected results queued in issue order
// Notes:   Reads and access results share one queue
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic ref_clk = 0, rst_n = 0, por_n = 0;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, s, p0, p1, p2;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, recCode;
	logic [2:0] accBlk = 0;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic accReq = 0, accWr = 0, accPriv = 0, progDone = 0, flashIntEn = 0;
	logic accGrant, accDenied, irq;
	logic [33:0] expQ[$];
	logic [1:0] bExp = prot_pkg::RESP_OKAY;
	int errTotal = 0, nCompared = 0;
	always #12.5 ref_clk = ~ref_clk;
	eeprom_block_protection i_dut (.ref_clk, .rst_n, .por_n, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .accReq, .accBlk, .accWr, .accPriv,
		.accGrant, .accDenied, .progDone, .engBusy(1'b0), .engCopy(1'b0), .engErase(1'b0),
		.engLowVolt(1'b0), .recCode, .flashIntEn, .irq);
	axil_host i_host (.ref_clk, .awready, .wready, .bvalid, .arready, .rvalid, .awaddr,
		.awvalid, .wdata, .wstrb, .wvalid, .bready, .araddr, .arvalid, .rready);
	// ----------------
	// Helpers
	// ----------------
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task chk(input logic [33:0] got, input logic [33:0] e);
		nCompared++;
		if (got !== e) begin
			errTotal++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, e);
		end
	endtask
	task stopTest;
		$display("Compared %0d mismatches %0d", nCompared, errTotal);
		if (errTotal == 0 && nCompared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		if (rvalid && rready)
			chk({rresp, rdata}, expQ.size() ? expQ.pop_front() : '1);
		if (accGrant || accDenied)
			chk({32'h0, accDenied, accGrant}, expQ.size() ? expQ.pop_front() : '1);
		if (bvalid && bready)
			chk({32'h0, bresp}, {32'h0, bExp});
	end
	task rd(input logic [7:0] a, input logic [33:0] e);
		expQ.push_back(e);
		i_host.rd(a);
	endtask
	task st(input logic [31:0] e);
		rd(prot_pkg::OFS_STATUS, {prot_pkg::RESP_OKAY, e | {28'h0, recCode, 2'h0}});
		i_host.wr(prot_pkg::OFS_STATUS, 32'h00000010);
	endtask
	task cmd(input logic [2:0] op, input logic [1:0] n, input logic [2:0] pr);
		i_host.wr(prot_pkg::OFS_CMD, {21'h0, pr, 1'b0, op, 2'h0, n});
	endtask
	task acc(input logic [2:0] b, input logic w, input logic p, input logic g);
		@(posedge ref_clk);
		accReq <= 1'b1;
		accBlk <= b;
		accWr <= w;
		accPriv <= p;
		expQ.push_back({32'h0, !g, g});
		@(posedge ref_clk);
		accReq <= 1'b0;
		@(posedge ref_clk);
	endtask
	task irqChk(input logic e);
		@(posedge ref_clk);
		progDone <= 1'b1;
		@(posedge ref_clk);
		progDone <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk({33'h0, irq}, {33'h0, e});
	endtask
	// ----------------
	// Scenarios
	// ----------------
	initial begin
		s = lfsr(32'h00000036);
		recCode = s[0] ? 2'h2 : 2'h1;
		p0 = s & 32'h7FFFFFFF;
		s = lfsr(s);
		p1 = s & 32'h7FFFFFFF;
		s = lfsr(s);
		p2 = s & 32'h7FFFFFFF;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		por_n <= 1'b1;
		st(32'h00000001);
		i_host.wr(prot_pkg::OFS_BLKSEL, 32'h00000001);
		i_host.wr(prot_pkg::OFS_PW0, p0);
		cmd(prot_pkg::OP_SETPW, 2'h1, 3'h0);
		st(32'h00000003);
		cmd(prot_pkg::OP_SETPW, 2'h1, 3'h0);
		st(32'h00000013);
		i_host.wr(prot_pkg::OFS_BLKSEL, 32'h00000002);
		cmd(prot_pkg::OP_SETPW, 2'h0, 3'h0);
		st(32'h00000011);
		i_host.wr(prot_pkg::OFS_PW0, 32'hFFFFFFFF);
		cmd(prot_pkg::OP_SETPW, 2'h1, 3'h0);
		st(32'h00000011);
		i_host.wr(prot_pkg::OFS_BLKSEL, 32'h00000001);
		cmd(prot_pkg::OP_PROT, 2'h0, {1'b0, prot_pkg::MODE_RO});
		cmd(prot_pkg::OP_LOCK, 2'h0, 3'h0);
		st(32'h00020002);
		cmd(prot_pkg::OP_PROT, 2'h0, {1'b0, prot_pkg::MODE_NA});
		st(32'h00020012);
		acc(3'h1, 1'b0, 1'b1, 1'b0);
		i_host.wr(prot_pkg::OFS_PW0, p0 ^ 32'h00000001);
		cmd(prot_pkg::OP_UNLOCK, 2'h1, 3'h0);
		st(32'h00020002);
		i_host.wr(prot_pkg::OFS_PW0, p0);
		cmd(prot_pkg::OP_UNLOCK, 2'h2, 3'h0);
		st(32'h00020002);
		cmd(prot_pkg::OP_UNLOCK, 2'h1, 3'h0);
		st(32'h00020003);
		acc(3'h1, 1'b0, 1'b1, 1'b1);
		acc(3'h1, 1'b1, 1'b1, 1'b0);
		st(32'h00020013);
		i_host.wr(prot_pkg::OFS_BLKSEL, 32'h00000003);
		cmd(prot_pkg::OP_PROT, 2'h0, {1'b0, prot_pkg::MODE_NA});
		acc(3'h3, 1'b0, 1'b1, 1'b0);
		acc(3'h2, 1'b1, 1'b1, 1'b1);
		i_host.wr(prot_pkg::OFS_BLKSEL, 32'h00000000);
		i_host.wr(prot_pkg::OFS_PW1, p1);
		i_host.wr(prot_pkg::OFS_PW2, p2);
		cmd(prot_pkg::OP_SETPW, 2'h3, 3'h0);
		cmd(prot_pkg::OP_PROT, 2'h0, 3'h4);
		acc(3'h2, 1'b0, 1'b0, 1'b0);
		acc(3'h2, 1'b0, 1'b1, 1'b1);
		cmd(prot_pkg::OP_LOCK, 2'h0, 3'h0);
		acc(3'h2, 1'b0, 1'b1, 1'b0);
		i_host.wr(prot_pkg::OFS_BLKSEL, 32'h00000001);
		st(32'h00000002);
		i_host.wr(prot_pkg::OFS_BLKSEL, 32'h00000000);
		cmd(prot_pkg::OP_UNLOCK, 2'h3, 3'h0);
		acc(3'h2, 1'b0, 1'b1, 1'b1);
		i_host.wr(prot_pkg::OFS_BLKSEL, 32'h00000001);
		st(32'h00020002);
		i_host.wr(prot_pkg::OFS_INTMASK, 32'h00000001);
		irqChk(1'b1);
		rd(prot_pkg::OFS_INTSTAT, {prot_pkg::RESP_OKAY, 32'h00000001});
		rd(prot_pkg::OFS_INTSTAT, {prot_pkg::RESP_OKAY, 32'h00000000});
		chk({33'h0, irq}, 34'h0);
		i_host.wr(prot_pkg::OFS_INTMASK, 32'h00000000);
		flashIntEn <= 1'b1;
		irqChk(1'b1);
		rd(prot_pkg::OFS_INTSTAT, {prot_pkg::RESP_OKAY, 32'h00000001});
		flashIntEn <= 1'b0;
		irqChk(1'b0);
		rd(prot_pkg::OFS_INTSTAT, {prot_pkg::RESP_OKAY, 32'h00000001});
		rd(8'h20, {prot_pkg::RESP_SLVERR, 32'h00000000});
		rst_n <= 1'b0;
		@(posedge ref_clk);
		rst_n <= 1'b1;
		st(32'h00040002);
		bExp <= prot_pkg::RESP_SLVERR;
		i_host.wr(8'h20, 32'h00000000);
		repeat (4) @(posedge ref_clk);
		stopTest;
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		errTotal++;
		stopTest;
	end
endmodule
`default_nettype wire
